//--- tssr_pkg.sv
// Shared constants and types for the temperature sensor serial readout
package tssr_pkg;

    // Result and frame layout
    localparam int RESULT_W = 14;
    localparam int FRAME_W = 16;
    localparam int SIGN_BIT_POSITION = 13;
    localparam int LEAD_ZEROS = 2;
    localparam int POWER_DOWN_BIT = 13;
    localparam int FRAME_LAST = 15;

    // Reset values
    localparam logic [13:0] RESULT_RST = 14'h0000;
    localparam logic [15:0] CONTROL_RST = 16'h0000;

    // Timing, in printed units, and the derived cycle counts
    localparam real REF_CLK_MHZ = 100.0;
    localparam real PERIOD_TIME_S = 1.5;
    localparam real CONV_TIME_MS = 1.2;
    localparam int PERIOD_CYCLES_DEF = int'(PERIOD_TIME_S * 1000000.0 * REF_CLK_MHZ);
    localparam int CONV_CYCLES_DEF = int'(CONV_TIME_MS * 1000.0 * REF_CLK_MHZ);

    // Conversion scheduler mode
    typedef enum logic {
        TSSR_NORMAL,
        TSSR_SHUTDOWN
    } tssr_mode_t;

endpackage

//--- tssr_sync3.sv
// Three-stage synchroniser; output follows once the last two stages agree
`timescale 1ns/1ps
`default_nettype none

module tssr_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);

    logic stage1;
    logic stage2;
    logic stage3;
    wire agree = (stage2 == stage3);

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            stage1 <= RESET_VAL;
            stage2 <= RESET_VAL;
            stage3 <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync_out <= RESET_VAL;
        end else if (agree) begin
            sync_out <= stage3;
        end
    end

endmodule

`default_nettype wire

//--- tssr_top.sv
// Temperature sensor digital core: conversion scheduler, result hand-off, serial slave port
`timescale 1ns/1ps
`default_nettype none

module tssr_top #(
    parameter int PERIOD_CYCLES = tssr_pkg::PERIOD_CYCLES_DEF,
    parameter int CONV_CYCLES = tssr_pkg::CONV_CYCLES_DEF
) (
    // Core clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Serial port pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_n,
    // Analog converter side
    input wire logic [13:0] adc_code,
    output logic analog_power_en,
    // Status
    output logic shutdown_active
);

    localparam int PW = $clog2(PERIOD_CYCLES + 1);
    localparam int CW = $clog2(CONV_CYCLES + 1);
    localparam logic [PW-1:0] PERIOD_LAST = PW'(PERIOD_CYCLES - 1);
    localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
    localparam logic [3:0] FRAME_LAST = 4'(tssr_pkg::FRAME_LAST);
    localparam logic [3:0] ONE4 = 4'h1;

    // ------------------------------------------------------------------
    // Serial clock domain
    // ------------------------------------------------------------------
    logic [3:0] rise_cnt;
    logic [15:0] rx_shift;
    logic [15:0] power_control;
    logic ctl_tgl;
    logic [3:0] fall_cnt;
    logic first_done;
    logic [13:0] temperature_result;
    logic dout;

    // Snapshot of the holding buffer, owned by the core domain
    logic [13:0] snapshot;

    wire [15:0] next_control = {rx_shift[14:0], sdi};
    wire last_rise = (rise_cnt == FRAME_LAST);
    wire [15:0] frame_word = {2'b00, temperature_result};
    wire [3:0] out_index = FRAME_LAST - fall_cnt;
    // Fall n presents frame bit n-1, counted from the top, so msb leads
    wire next_dout = frame_word[out_index];
    wire first_fall = ~first_done;

    // Select high holds the bit counters, receive shift and output bit in reset, so the clock is ignored
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rise_cnt <= 4'h0;
        end else begin
            rise_cnt <= rise_cnt + ONE4;
        end
    end

    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            rx_shift <= tssr_pkg::CONTROL_RST;
        end else begin
            rx_shift <= next_control;
        end
    end

    // Every sixteenth rising edge of a frame commits (16th, 32nd, ...); a short frame leaves it alone
    always_ff @(posedge sclk or posedge srst) begin
        if (srst) begin
            power_control <= tssr_pkg::CONTROL_RST;
            ctl_tgl <= 1'b0;
        end else if (!cs_n && last_rise) begin
            power_control <= next_control;
            ctl_tgl <= ~ctl_tgl;
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fall_cnt <= 4'h0;
            first_done <= 1'b0;
            dout <= 1'b0;
        end else begin
            fall_cnt <= fall_cnt + ONE4;
            first_done <= 1'b1;
            dout <= next_dout;
        end
    end

    // Snapshot is frozen while selected, so this multi-bit read is stable
    always_ff @(negedge sclk or posedge srst) begin
        if (srst) begin
            temperature_result <= tssr_pkg::RESULT_RST;
        end else if (!cs_n && first_fall) begin
            temperature_result <= snapshot;
        end
    end

    assign sdo = dout;
    assign sdo_oe_n = cs_n;

    // ------------------------------------------------------------------
    // Crossing into the core domain
    // ------------------------------------------------------------------
    logic cs_idle;
    logic cs_idle_q;
    logic ctl_tgl_s;
    logic ctl_tgl_q;

    tssr_sync3 #(
        .RESET_VAL(1'b1)
    ) u_cs_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(cs_n),
        .sync_out(cs_idle)
    );

    tssr_sync3 #(
        .RESET_VAL(1'b0)
    ) u_ctl_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(ctl_tgl),
        .sync_out(ctl_tgl_s)
    );

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            cs_idle_q <= 1'b1;
            ctl_tgl_q <= 1'b0;
        end else begin
            cs_idle_q <= cs_idle;
            ctl_tgl_q <= ctl_tgl_s;
        end
    end

    wire frame_end_ev = cs_idle & ~cs_idle_q;
    wire ctl_ev = ctl_tgl_s ^ ctl_tgl_q;
    // Control word stays put for at least 16 serial clocks after the toggle
    wire pd_req = power_control[tssr_pkg::POWER_DOWN_BIT];

    // ------------------------------------------------------------------
    // Conversion scheduler
    // ------------------------------------------------------------------
    tssr_pkg::tssr_mode_t mode;
    tssr_pkg::tssr_mode_t next_mode;
    logic [PW-1:0] period_cnt;
    logic [PW-1:0] next_period_cnt;
    logic busy;
    logic [CW-1:0] conv_cnt;
    logic [13:0] holding;

    wire in_normal = (mode == tssr_pkg::TSSR_NORMAL);
    wire stays_normal = (next_mode == tssr_pkg::TSSR_NORMAL);
    wire sleep_ev = ctl_ev & pd_req;
    wire wake_ev = ctl_ev & ~pd_req & ~in_normal;
    wire tick_ev = in_normal & stays_normal & (period_cnt == PERIOD_LAST);
    wire frame_restart = frame_end_ev & stays_normal;
    wire restart_tmr = wake_ev | frame_restart;
    // A running conversion absorbs any further start request
    wire start_conv = ~busy & (restart_tmr | tick_ev);
    wire conv_last = busy & (conv_cnt == CONV_LAST);

    always_comb begin
        next_mode = mode;
        if (sleep_ev) begin
            next_mode = tssr_pkg::TSSR_SHUTDOWN;
        end else if (wake_ev) begin
            next_mode = tssr_pkg::TSSR_NORMAL;
        end
    end

    always_comb begin
        case (mode)
            tssr_pkg::TSSR_NORMAL: begin
                if (restart_tmr || tick_ev) begin
                    next_period_cnt = '0;
                end else begin
                    next_period_cnt = period_cnt + PW'(1);
                end
            end
            tssr_pkg::TSSR_SHUTDOWN: begin
                // Oscillator stopped: the timer holds until a wake restarts it
                if (wake_ev) begin
                    next_period_cnt = '0;
                end else begin
                    next_period_cnt = period_cnt;
                end
            end
            default: begin
                next_period_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode <= tssr_pkg::TSSR_NORMAL;
            period_cnt <= '0;
        end else begin
            mode <= next_mode;
            period_cnt <= next_period_cnt;
        end
    end

    // Shutdown never cuts a conversion short; only completion ends it
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            busy <= 1'b0;
            conv_cnt <= '0;
        end else if (busy) begin
            if (conv_last) begin
                busy <= 1'b0;
            end else begin
                conv_cnt <= conv_cnt + CW'(1);
            end
        end else if (start_conv) begin
            busy <= 1'b1;
            conv_cnt <= '0;
        end
    end

    // Code from the converter is already two's complement with the sign on top
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            holding <= tssr_pkg::RESULT_RST;
        end else if (conv_last) begin
            holding <= adc_code;
        end
    end

    // Frozen while selected: a result finishing mid-read waits in holding
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            snapshot <= tssr_pkg::RESULT_RST;
        end else if (cs_idle) begin
            snapshot <= holding;
        end
    end

    assign analog_power_en = busy;
    assign shutdown_active = ~in_normal;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    wire start_ok = in_normal | wake_ev;

    conv_length_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $fell(busy) |-> ($past(conv_cnt) == CONV_LAST)
    ) else $error("conversion ended at the wrong count");

    no_start_sd_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        $rose(busy) |-> $past(start_ok)
    ) else $error("conversion started in shutdown");

    timer_frozen_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (!in_normal && !wake_ev) |=> $stable(period_cnt)
    ) else $error("timer moved during shutdown");

    period_start_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (in_normal && !ctl_ev && period_cnt == PERIOD_LAST) |=> (busy && period_cnt == '0)
    ) else $error("period expiry did not start a conversion");

    frame_restart_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        // A conversion still running at frame end, even in its last cycle, absorbs the start
        (frame_end_ev && in_normal && !ctl_ev) |=> ((busy || $past(busy)) && period_cnt == '0)
    ) else $error("frame end did not restart timer and conversion");

    wake_start_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        wake_ev |=> ((busy || $past(busy)) && !shutdown_active)
    ) else $error("wake did not start a conversion");

    conv_runs_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        (busy && conv_cnt != CONV_LAST) |=> busy
    ) else $error("conversion aborted early");

    snap_frozen_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        !cs_idle |=> $stable(snapshot)
    ) else $error("snapshot changed during a frame");

    lead_zeros_a: assert property (
        @(posedge sclk) disable iff (cs_n)
        (fall_cnt == 4'h1 || fall_cnt == 4'h2) |-> !sdo
    ) else $error("leading bits not zero");

    ctl_commit_a: assert property (
        @(posedge sclk) disable iff (cs_n)
        (rise_cnt != FRAME_LAST) |=> (ctl_tgl == $past(ctl_tgl))
    ) else $error("control loaded before the last rising edge");

    sleep_enter_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        sleep_ev |=> shutdown_active
    ) else $error("shutdown request not applied");

    result_capture_a: assert property (
        @(posedge ref_clk) disable iff (srst)
        conv_last |=> (holding == $past(adc_code))
    ) else $error("finished conversion not buffered");

endmodule

`default_nettype wire

//--- tssr_master.sv
// Serial master model driving select, clock and data and capturing returned bits
`timescale 1ns/1ps
`default_nettype none

module tssr_master (
    // Serial pins
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    wire logic sdo_line;

    // Released output floats, so an undriven bit never passes for data
    assign sdo_line = sdo_oe_n ? 1'bz : sdo;

    initial begin
        sclk = 1'h1;
        cs_n = 1'h1;
        sdi = 1'h0;
    end

    // Clock idles high and toggles only inside frames, 6 ns period
    task automatic frame(input logic [31:0] wr, input int n, input logic sel, output logic [31:0] rd);
        rd = 32'h0000_0000;
        cs_n = !sel;
        #50;
        for (int i = 0; i < n; i++) begin
            sclk = 1'h0;
            sdi = wr[31 - i];
            #3;
            sclk = 1'h1;
            rd[31 - i] = sdo_line;
            #3;
        end
        // Callers pick n; fewer than 16 clocks is a deliberate short write
        #3;
        cs_n = 1'h1;
        sdi = ~sdi;
        #50;
    endtask
endmodule

`default_nettype wire

//--- temp_sensor_serial_readout_tb.sv
// Self-checking testbench for the temperature sensor serial readout
`timescale 1ns/1ps
`default_nettype none

module temp_sensor_serial_readout_tb;
    localparam int PERIOD = 200;
    localparam int CONV = 20;
    logic ref_clk;
    logic srst;
    logic [13:0] adc_code;
    wire logic sclk;
    wire logic cs_n;
    wire logic sdi;
    wire logic sdo;
    wire logic sdo_oe_n;
    wire logic analog_power_en;
    wire logic shutdown_active;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    int n;
    logic [31:0] rd;

    tssr_top #(.PERIOD_CYCLES(PERIOD), .CONV_CYCLES(CONV)) i_tssr_top (
        .ref_clk(ref_clk),
        .srst(srst),
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe_n(sdo_oe_n),
        .adc_code(adc_code),
        .analog_power_en(analog_power_en),
        .shutdown_active(shutdown_active)
    );

    tssr_master i_tssr_master (
        .sclk(sclk),
        .cs_n(cs_n),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe_n(sdo_oe_n)
    );

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Sampled 1 ns after the edge so the flag has settled; n counts edges
    task automatic wait_pwr(input logic v, input int lim);
        n = 0;
        while (analog_power_en !== v && n < lim) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    task automatic rd_frame(input logic [31:0] wr, input int k);
        i_tssr_master.frame(wr, k, 1'h1, rd);
    endtask

    task automatic set_adc(input logic [13:0] v);
        @(posedge ref_clk);
        adc_code <= v;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            give_verdict();
        end
    end

    initial begin
        srst = 1'h1;
        adc_code = 14'h3B00;
        repeat (12) @(posedge ref_clk);
        srst <= 1'h0;
        @(posedge ref_clk);
        #1;
        check("power idle", analog_power_en, 32'h0);
        check("mode", shutdown_active, 32'h0);
        check("oe idle", sdo_oe_n, 32'h1);
        wait_pwr(1'h1, 300);
        check("period", 32'(n > 190 && n < 210), 32'h1);
        wait_pwr(1'h0, 100);
        check("conv len", n, CONV);
        set_adc(14'h0320);
        rd_frame(32'h0000_0000, 32);
        check("wrap read", rd, 32'h3B00_3B00);
        check("oe release", sdo_oe_n, 32'h1);
        wait_pwr(1'h1, 20);
        check("frame end conv", 32'(n < 20), 32'h1);
        wait_pwr(1'h0, 100);
        check("conv done", n, CONV);
        rd_frame(32'h0000_0000, 16);
        check("new result", rd[31:16], 32'h0320);
        wait_pwr(1'h1, 20);
        wait_pwr(1'h0, 100);
        // Fifteen clocks with the power-down bit set must not commit
        rd_frame(32'h2000_0000, 15);
        repeat (10) @(posedge ref_clk);
        check("fifteen clocks", shutdown_active, 32'h0);
        wait_pwr(1'h0, 100);
        // Third bit set asks for shutdown
        rd_frame(32'h2000_0000, 16);
        repeat (10) @(posedge ref_clk);
        check("shutdown", shutdown_active, 32'h1);
        set_adc(14'h3FFF);
        wait_pwr(1'h1, 300);
        check("no conv", n, 32'd300);
        rd_frame(32'h2000_0000, 16);
        check("held result", rd[31:16], 32'h0320);
        rd_frame(32'h0000_0000, 8);
        repeat (10) @(posedge ref_clk);
        check("short write", shutdown_active, 32'h1);
        i_tssr_master.frame(32'h0000_0000, 16, 1'h0, rd);
        repeat (10) @(posedge ref_clk);
        check("unselected", shutdown_active, 32'h1);
        rd_frame(32'h0000_0000, 16);
        wait_pwr(1'h1, 20);
        check("wake conv", 32'(n < 20), 32'h1);
        check("wake", shutdown_active, 32'h0);
        // Conversion still running when this read begins
        rd_frame(32'h0000_0000, 16);
        check("busy read", rd[31:16], 32'h0320);
        wait_pwr(1'h0, 100);
        repeat (5) @(posedge ref_clk);
        rd_frame(32'h0000_0000, 16);
        check("sign result", rd[31:16], 32'h3FFF);
        give_verdict();
    end
endmodule

`default_nettype wire
